// >>> design/ulf_pkg.sv
package ulf_pkg;

    localparam int unsigned ADDR_W = 3;
    localparam logic [2:0] OFF_IRQ_ID = 3'h2;
    localparam logic [2:0] OFF_LINE_FMT = 3'h3;
    localparam logic [7:0] LINE_FMT_RST = 8'h00;

    localparam int LF_DIV = 7;
    localparam int LF_BRK = 6;
    localparam int LF_STICK = 5;
    localparam int LF_EVEN = 4;
    localparam int LF_PEN = 3;
    localparam int LF_STOP = 2;

    localparam int unsigned NSRC = 5;
    localparam logic [2:0] SRC_LINE = 3'h0;
    localparam logic [2:0] SRC_RXDATA = 3'h1;
    localparam logic [2:0] SRC_RXTMO = 3'h2;
    localparam logic [2:0] SRC_TXEMPTY = 3'h3;
    localparam logic [2:0] SRC_MODEM = 3'h4;

    localparam logic [3:0] ID_LINE = 4'h6;
    localparam logic [3:0] ID_RXDATA = 4'h4;
    localparam logic [3:0] ID_RXTMO = 4'hc;
    localparam logic [3:0] ID_TXEMPTY = 4'h2;
    localparam logic [3:0] ID_MODEM = 4'h0;
    localparam logic [3:0] ID_NONE = 4'h1;
    localparam logic [1:0] FIFO_ON_BITS = 2'h3;
    localparam logic [1:0] FIFO_OFF_BITS = 2'h0;

    localparam logic [2:0] HALVES_BIT = 3'h2;
    localparam logic [2:0] HALVES_STOP1 = 3'h2;
    localparam logic [2:0] HALVES_STOP15 = 3'h3;
    localparam logic [2:0] HALVES_STOP2 = 3'h4;
    localparam logic [2:0] LAST_BIT_BASE = 3'h4;

    typedef enum logic [2:0] {
        TX_IDLE = 3'h0,
        TX_START = 3'h1,
        TX_DATA = 3'h3,
        TX_PAR = 3'h2,
        TX_STOP = 3'h6
    } ulf_tx_state_t;

    function automatic logic [7:0] word_mask(input logic [1:0] wl);
        case (wl)
            2'h0: word_mask = 8'h1f;
            2'h1: word_mask = 8'h3f;
            2'h2: word_mask = 8'h7f;
            default: word_mask = 8'hff;
        endcase
    endfunction : word_mask

    function automatic logic par_bit(input logic [7:0] d,
                                     input logic [7:0] fmt);
        logic ones;
        ones = ^(d & word_mask(fmt[1:0]));
        if (fmt[LF_STICK])
            par_bit = ~fmt[LF_EVEN];
        else if (fmt[LF_EVEN])
            par_bit = ones;
        else
            par_bit = ~ones;
    endfunction : par_bit

    function automatic logic [2:0] stop_halves(input logic [7:0] fmt);
        if (!fmt[LF_STOP])
            stop_halves = HALVES_STOP1;
        else if (fmt[1:0] == 2'h0)
            stop_halves = HALVES_STOP15;
        else
            stop_halves = HALVES_STOP2;
    endfunction : stop_halves

endpackage : ulf_pkg

// >>> design/ulf_irq_rank.sv
`timescale 1ns/100ps
module ulf_irq_rank (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Source events, one-cycle pulses
    input wire logic [4:0] src_set_in,
    // Status register read
    input wire logic rd_ack_in,
    // Report
    output logic [3:0] id_code_out,
    output logic [4:0] pend_out
);

    logic [4:0] pend_q;
    logic [4:0] pend_d;
    logic cur_vld_q;
    logic cur_vld_d;
    logic [2:0] cur_q;
    logic [2:0] cur_d;

    wire any_pend = |pend_q;
    wire [2:0] top_src =
        pend_q[0] ? ulf_pkg::SRC_LINE :
        pend_q[1] ? ulf_pkg::SRC_RXDATA :
        pend_q[2] ? ulf_pkg::SRC_RXTMO :
        pend_q[3] ? ulf_pkg::SRC_TXEMPTY : ulf_pkg::SRC_MODEM;
    // Latched source is not preempted by a later higher one
    wire [2:0] rep_src = cur_vld_q ? cur_q : top_src;
    wire rep_vld = cur_vld_q | any_pend;
    wire clr_hit = rd_ack_in & rep_vld;
    wire [4:0] clr_mask = clr_hit ? (5'h01 << rep_src) : 5'h00;

    // Set wins over a same-cycle clear
    assign pend_d = (pend_q & ~clr_mask) | src_set_in;

    always_comb begin
        cur_vld_d = cur_vld_q;
        cur_d = cur_q;
        if (clr_hit) begin
            cur_vld_d = 1'b0;
        end else if (!cur_vld_q && any_pend) begin
            cur_vld_d = 1'b1;
            cur_d = top_src;
        end
    end

    always_comb begin
        case (rep_src)
            ulf_pkg::SRC_LINE: id_code_out = ulf_pkg::ID_LINE;
            ulf_pkg::SRC_RXDATA: id_code_out = ulf_pkg::ID_RXDATA;
            ulf_pkg::SRC_RXTMO: id_code_out = ulf_pkg::ID_RXTMO;
            ulf_pkg::SRC_TXEMPTY: id_code_out = ulf_pkg::ID_TXEMPTY;
            default: id_code_out = ulf_pkg::ID_MODEM;
        endcase
        if (!rep_vld)
            id_code_out = ulf_pkg::ID_NONE;
    end

    assign pend_out = pend_q;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pend_q <= 5'h00;
            cur_vld_q <= 1'b0;
            cur_q <= 3'h0;
        end else begin
            pend_q <= pend_d;
            cur_vld_q <= cur_vld_d;
            cur_q <= cur_d;
        end
    end

endmodule : ulf_irq_rank

// >>> design/ulf_uart_core.sv
`timescale 1ns/100ps
module ulf_uart_core (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Register port
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rd_data_out,
    // Interrupt sources, same clock, one-cycle pulses
    input wire logic receive_line_condition_in,
    input wire logic receive_data_available_in,
    input wire logic receive_timeout_in,
    input wire logic transmit_holding_empty_in,
    input wire logic modem_line_change_in,
    input wire logic fifo_en_in,
    output logic int_pending_out,
    // Format to the rest of the datapath
    output logic divisor_access_out,
    output logic [1:0] word_len_out,
    output logic [2:0] stop_halves_out,
    output logic parity_en_out,
    // Transmit framer
    input wire logic half_tick_in,
    input wire logic [7:0] tx_data_in,
    input wire logic tx_load_in,
    output logic tx_ready_out,
    output logic tx_serial_out,
    // Receive parity check
    input wire logic [7:0] rx_data_in,
    input wire logic rx_par_in,
    input wire logic rx_chk_in,
    output logic rx_par_err_out
);

    logic [7:0] line_fmt_q;
    logic [7:0] line_fmt_d;
    logic [7:0] rd_data_q;
    logic [7:0] rd_data_d;
    logic rx_par_err_q;
    logic rx_par_err_d;
    logic [3:0] id_code;

    // Register decode
    wire sel_id = addr_in == ulf_pkg::OFF_IRQ_ID;
    wire sel_fmt = addr_in == ulf_pkg::OFF_LINE_FMT;
    wire id_rd = rd_in & sel_id;
    // Status register is read-only; writes there fall through
    wire fmt_wr = wr_in & sel_fmt;
    wire [1:0] fifo_bits =
        fifo_en_in ? ulf_pkg::FIFO_ON_BITS
                   : ulf_pkg::FIFO_OFF_BITS;
    wire [7:0] id_word = {fifo_bits, 2'h0, id_code};
    wire [7:0] rd_sel =
        sel_id ? id_word : sel_fmt ? line_fmt_q : 8'h00;

    assign line_fmt_d = fmt_wr ? wr_data_in : line_fmt_q;
    assign rd_data_d = rd_in ? rd_sel : 8'h00;

    ulf_irq_rank u_rank (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .src_set_in({modem_line_change_in,
                     transmit_holding_empty_in,
                     receive_timeout_in,
                     receive_data_available_in,
                     receive_line_condition_in}),
        .rd_ack_in(id_rd),
        .id_code_out(id_code),
        .pend_out()
    );

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            line_fmt_q <= ulf_pkg::LINE_FMT_RST;
            rd_data_q <= 8'h00;
        end else begin
            line_fmt_q <= line_fmt_d;
            rd_data_q <= rd_data_d;
        end
    end

    assign rd_data_out = rd_data_q;
    assign int_pending_out = ~id_code[0];

    // Format decode
    wire fmt_brk = line_fmt_q[ulf_pkg::LF_BRK];
    wire fmt_pen = line_fmt_q[ulf_pkg::LF_PEN];
    wire [2:0] stop_len = ulf_pkg::stop_halves(line_fmt_q);
    wire [7:0] data_mask = ulf_pkg::word_mask(line_fmt_q[1:0]);

    assign divisor_access_out = line_fmt_q[ulf_pkg::LF_DIV];
    assign word_len_out = line_fmt_q[1:0];
    assign stop_halves_out = stop_len;
    assign parity_en_out = fmt_pen;

    // Receive check uses the same parity function as transmit
    wire rx_exp = ulf_pkg::par_bit(rx_data_in, line_fmt_q);
    wire rx_bad = fmt_pen & (rx_par_in != rx_exp);

    assign rx_par_err_d = rx_chk_in ? rx_bad : rx_par_err_q;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            rx_par_err_q <= 1'b0;
        else
            rx_par_err_q <= rx_par_err_d;
    end

    assign rx_par_err_out = rx_par_err_q;

    // Transmit framer, counted in half bit times
    ulf_pkg::ulf_tx_state_t st_q;
    ulf_pkg::ulf_tx_state_t st_d;
    logic [2:0] half_q;
    logic [2:0] half_d;
    logic [2:0] bit_q;
    logic [2:0] bit_d;
    logic [7:0] sh_q;
    logic [7:0] sh_d;
    logic par_q;
    logic par_d;
    logic line_q;
    logic line_d;

    wire [7:0] tx_masked = tx_data_in & data_mask;
    wire [2:0] last_bit = ulf_pkg::LAST_BIT_BASE + {1'b0, line_fmt_q[1:0]};
    wire in_stop = st_q == ulf_pkg::TX_STOP;
    wire [2:0] seg_len = in_stop ? stop_len : ulf_pkg::HALVES_BIT;
    wire [2:0] half_inc = half_q + 3'h1;
    wire seg_end = half_tick_in & (half_inc == seg_len);
    wire tx_start = (st_q == ulf_pkg::TX_IDLE) & tx_load_in;

    // Format is read live; change it only while the framer is idle
    always_comb begin
        st_d = st_q;
        half_d = half_q;
        bit_d = bit_q;
        sh_d = sh_q;
        par_d = par_q;
        if (half_tick_in)
            half_d = seg_end ? 3'h0 : half_inc;
        case (st_q)
            ulf_pkg::TX_IDLE: begin
                half_d = 3'h0;
                if (tx_load_in) begin
                    st_d = ulf_pkg::TX_START;
                    sh_d = tx_masked;
                    par_d = ulf_pkg::par_bit(tx_data_in,
                                             line_fmt_q);
                end
            end
            ulf_pkg::TX_START: begin
                if (seg_end) begin
                    st_d = ulf_pkg::TX_DATA;
                    bit_d = 3'h0;
                end
            end
            ulf_pkg::TX_DATA: begin
                if (seg_end) begin
                    sh_d = {1'b0, sh_q[7:1]};
                    bit_d = bit_q + 3'h1;
                    if (bit_q == last_bit)
                        st_d = fmt_pen ? ulf_pkg::TX_PAR
                                       : ulf_pkg::TX_STOP;
                end
            end
            ulf_pkg::TX_PAR: begin
                if (seg_end)
                    st_d = ulf_pkg::TX_STOP;
            end
            ulf_pkg::TX_STOP: begin
                if (seg_end)
                    st_d = ulf_pkg::TX_IDLE;
            end
            default: begin
                st_d = ulf_pkg::TX_IDLE;
            end
        endcase
    end

    always_comb begin
        case (st_d)
            ulf_pkg::TX_START: line_d = 1'b0;
            ulf_pkg::TX_DATA: line_d = sh_d[0];
            ulf_pkg::TX_PAR: line_d = par_d;
            default: line_d = 1'b1;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= ulf_pkg::TX_IDLE;
            half_q <= 3'h0;
            bit_q <= 3'h0;
            sh_q <= 8'h00;
            par_q <= 1'b0;
            line_q <= 1'b1;
        end else begin
            st_q <= st_d;
            half_q <= half_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            par_q <= par_d;
            line_q <= line_d;
        end
    end

    assign tx_ready_out = (st_q == ulf_pkg::TX_IDLE) & ~tx_start;
    // Framer keeps running under break; only the line is overridden
    assign tx_serial_out = line_q & ~fmt_brk;

endmodule : ulf_uart_core

// >>> sim/ulf_core_assertions.sv
`timescale 1ns/100ps
module ulf_core_chk (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // Register port
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rd_data_out,
    // Status and format
    input wire logic fifo_en_in,
    input wire logic int_pending_out,
    input wire logic divisor_access_out,
    input wire logic [1:0] word_len_out,
    input wire logic [2:0] stop_halves_out,
    input wire logic parity_en_out,
    input wire logic tx_serial_out
);
    logic [7:0] fmt_q;
    wire fmt_wr = wr_in && addr_in == ulf_pkg::OFF_LINE_FMT;
    wire fmt_rd = rd_in && addr_in == ulf_pkg::OFF_LINE_FMT;
    wire id_rd = rd_in && addr_in == ulf_pkg::OFF_IRQ_ID;

    // Shadow fed only by host writes, so a stuck register shows up
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            fmt_q <= 8'h00;
        else if (fmt_wr)
            fmt_q <= wr_data_in;
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_id_rd;
        id_rd;
    endsequence
    sequence s_fmt_rd;
        fmt_rd;
    endsequence

    a_fmt_fields: assert property (
        divisor_access_out == fmt_q[7] && parity_en_out == fmt_q[3])
        else $error("format fields differ from last write");
    a_word_len: assert property (word_len_out == fmt_q[1:0])
        else $error("word length differs from last write");
    a_stop_len: assert property (stop_halves_out ==
        (!fmt_q[2] ? 3'h2 : (fmt_q[1:0] == 2'h0 ? 3'h3 : 3'h4)))
        else $error("stop length wrong");
    a_break_low: assert property (fmt_q[6] |-> !tx_serial_out)
        else $error("serial line not low during break");
    a_fmt_readback: assert property (s_fmt_rd |=> rd_data_out == fmt_q)
        else $error("format readback wrong");
    a_idle_bit: assert property (
        s_id_rd |=> rd_data_out[0] == !$past(int_pending_out))
        else $error("status bit zero wrong");
    a_fifo_bits: assert property (s_id_rd |=>
        rd_data_out[7:4] == {{2{$past(fifo_en_in)}}, 2'h0})
        else $error("status upper bits wrong");
    a_code_legal: assert property (s_id_rd |=>
        rd_data_out[3:0] inside {4'h6, 4'h4, 4'hc, 4'h2, 4'h0, 4'h1})
        else $error("status code not legal");
    a_pend_hold: assert property (
        int_pending_out && !id_rd |=> int_pending_out)
        else $error("pending dropped without a status read");
endmodule : ulf_core_chk

bind ulf_uart_core ulf_core_chk i_ulf_core_chk (.*);

// >>> sim/ulf_host_model.sv
`timescale 1ns/100ps
module ulf_host_model (
    // Clock
    input wire logic sys_clk_in,
    // Register port
    input wire logic [7:0] rd_data_in,
    output logic [2:0] addr_out,
    output logic [7:0] wr_data_out,
    output logic wr_out,
    output logic rd_out
);
    initial begin
        addr_out = 3'h0;
        wr_data_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        addr_out <= a;
        wr_data_out <= d;
        wr_out <= 1'b1;
        @(posedge sys_clk_in);
        wr_out <= 1'b0;
        // Released data is scrambled so a late sample cannot pass
        wr_data_out <= ~d;
    endtask : wr_reg

    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge sys_clk_in);
        rd_out <= 1'b0;
        #1;
        d = rd_data_in;
    endtask : rd_reg
endmodule : ulf_host_model

// >>> sim/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [2:0] addr_in;
    logic [7:0] wr_data_in, rd_data_out, tx_data_in = 8'h00;
    logic wr_in, rd_in, fifo_en_in = 1'b0, int_pending_out;
    logic receive_line_condition_in = 1'b0, receive_data_available_in = 1'b0;
    logic receive_timeout_in = 1'b0, transmit_holding_empty_in = 1'b0;
    logic modem_line_change_in = 1'b0, divisor_access_out, parity_en_out;
    logic [1:0] word_len_out;
    logic [2:0] stop_halves_out;
    logic half_tick_in = 1'b1, tx_load_in = 1'b0, tx_ready_out;
    logic tx_serial_out, rx_par_in = 1'b0, rx_chk_in = 1'b0, rx_par_err_out;
    logic [7:0] rx_data_in = 8'h00;
    int n_fail = 0, compares = 0, cyc = 0;
    localparam logic [3:0] CODES [6] = '{4'h6, 4'h4, 4'hc, 4'h2, 4'h0, 4'h1};
    localparam logic [7:0] FMTS [7] = '{8'h00, 8'h0d, 8'h1a, 8'h2f,
                                         8'h3b, 8'h04, 8'h80};

    ulf_uart_core i_ulf_uart_core (.*);
    ulf_host_model i_ulf_host_model (.sys_clk_in(sys_clk_in),
        .rd_data_in(rd_data_out), .addr_out(addr_in),
        .wr_data_out(wr_data_in), .wr_out(wr_in), .rd_out(rd_in));

    always #5 sys_clk_in = ~sys_clk_in;

    task automatic conclude();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude

    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            conclude();
        end
    end

    task automatic chk8(string w, logic [7:0] e, logic [7:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", w, e, g);
        end
    endtask : chk8

    task automatic chk1(string w, logic e, logic g);
        chk8(w, {7'h00, e}, {7'h00, g});
    endtask : chk1

    task automatic rd_chk(string w, logic [2:0] a, logic [7:0] e);
        logic [7:0] d;
        i_ulf_host_model.rd_reg(a, d);
        chk8(w, e, d);
    endtask : rd_chk

    task automatic skip(int c);
        repeat (c) @(posedge sys_clk_in);
        #1;
    endtask : skip

    task automatic pulse(logic [4:0] s);
        @(posedge sys_clk_in);
        {modem_line_change_in, transmit_holding_empty_in, receive_timeout_in,
         receive_data_available_in, receive_line_condition_in} <= s;
        @(posedge sys_clk_in);
        {modem_line_change_in, transmit_holding_empty_in, receive_timeout_in,
         receive_data_available_in, receive_line_condition_in} <= 5'h00;
    endtask : pulse

    function automatic logic par_exp(logic [7:0] d, logic [7:0] f);
        logic ones;
        ones = ^(d & (8'hff >> (3 - f[1:0])));
        if (f[5])
            return !f[4];
        return f[4] ? ones : !ones;
    endfunction : par_exp

    task automatic send(logic [7:0] f);
        logic [7:0] d;
        int h;
        d = 8'hb3;
        h = !f[2] ? 2 : (f[1:0] == 2'h0 ? 3 : 4);
        i_ulf_host_model.wr_reg(ulf_pkg::OFF_LINE_FMT, f);
        rd_chk("fmt", ulf_pkg::OFF_LINE_FMT, f);
        chk1("div", f[7], divisor_access_out);
        chk1("pen", f[3], parity_en_out);
        chk8("wl", {6'h00, f[1:0]}, {6'h00, word_len_out});
        chk8("stop", {5'h00, !f[2] ? 3'h2 : (f[1:0] == 2'h0 ? 3'h3 : 3'h4)},
             {5'h00, stop_halves_out});
        @(posedge sys_clk_in);
        tx_data_in <= d;
        tx_load_in <= 1'b1;
        @(posedge sys_clk_in);
        tx_load_in <= 1'b0;
        repeat (8) begin
            skip(1);
            if (!tx_serial_out)
                break;
        end
        // Each bit spans two ticks; sample in its second cycle
        skip(2);
        for (int k = 0; k < 5 + f[1:0]; k++) begin
            chk1("data", d[k], tx_serial_out);
            skip(2);
        end
        if (f[3]) begin
            chk1("par", par_exp(d, f), tx_serial_out);
            skip(2);
        end
        chk1("stop", 1'b1, tx_serial_out);
        // Idle exactly h halves after stop began; next format write waits
        skip(h - 2);
        chk1("busy", 1'b0, tx_ready_out);
        skip(1);
        chk1("rdy", 1'b1, tx_ready_out);
    endtask : send

    task automatic rxc(logic [7:0] d, logic p, logic e);
        @(posedge sys_clk_in);
        rx_data_in <= d;
        rx_par_in <= p;
        rx_chk_in <= 1'b1;
        @(posedge sys_clk_in);
        rx_chk_in <= 1'b0;
        #1;
        chk1("rxerr", e, rx_par_err_out);
    endtask : rxc

    initial begin
        repeat (10) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        rd_chk("id", ulf_pkg::OFF_IRQ_ID, 8'h01);
        rd_chk("fmt", ulf_pkg::OFF_LINE_FMT, 8'h00);
        i_ulf_host_model.wr_reg(ulf_pkg::OFF_IRQ_ID, 8'hff);
        rd_chk("id", ulf_pkg::OFF_IRQ_ID, 8'h01);
        rd_chk("none", 3'h7, 8'h00);
        @(posedge sys_clk_in);
        fifo_en_in <= 1'b1;
        pulse(5'h1f);
        skip(0);
        chk1("pend", 1'b1, int_pending_out);
        foreach (CODES[i])
            rd_chk("id", ulf_pkg::OFF_IRQ_ID,
                   {4'hc, CODES[i]});
        chk1("pend", 1'b0, int_pending_out);
        @(posedge sys_clk_in);
        fifo_en_in <= 1'b0;
        pulse(5'h08);
        skip(3);
        pulse(5'h01);
        rd_chk("id", ulf_pkg::OFF_IRQ_ID, 8'h02);
        rd_chk("id", ulf_pkg::OFF_IRQ_ID, 8'h06);
        rd_chk("id", ulf_pkg::OFF_IRQ_ID, 8'h01);
        foreach (FMTS[i])
            send(FMTS[i]);
        // Host programs the checker with the transmit format
        i_ulf_host_model.wr_reg(ulf_pkg::OFF_LINE_FMT, 8'h1b);
        rxc(8'h03, 1'b0, 1'b0);
        rxc(8'h03, 1'b1, 1'b1);
        i_ulf_host_model.wr_reg(ulf_pkg::OFF_LINE_FMT, 8'h3b);
        rxc(8'h03, 1'b1, 1'b1);
        i_ulf_host_model.wr_reg(ulf_pkg::OFF_LINE_FMT, 8'h40);
        skip(2);
        chk1("brk", 1'b0, tx_serial_out);
        skip(20);
        chk1("brk", 1'b0, tx_serial_out);
        i_ulf_host_model.wr_reg(ulf_pkg::OFF_LINE_FMT, 8'h00);
        rxc(8'h03, 1'b1, 1'b0);
        chk1("brk", 1'b1, tx_serial_out);
        conclude();
    end
endmodule : testbench
